// [src/otg_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "otg_consts.svh"
// Function
// - forward limit inactive blocks forward motion
// - reverse limit inactive blocks reverse motion
// - motion away from tripped limit allowed
// - forward limit usable or ignored
// - reverse limit usable or ignored
// - stop method coast, decel clamp, decel coast
// - zero clamp holds zero position reference
// - torque control coasts from run or decel; a stop already clamped stays clamped
// - estop torque 0 to 800, reset 800
// - estop torque saturated at motor maximum
// - latch warning on trip while powered
// - warning enable off by default, immediate
// - warning only for reference direction side
// - no reference: either limit warns
// - no warning with motor power off
// - power-on into existing overtravel no warning
// - clear command always accepted
// - after clear, rearm only after overtravel ends
// - software limit excess also warns
// - warning only reports, blocks nothing
// - stop processing despite unreached target
// - warning on selected general output
module otg_top import otg_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // limit switch pins, high means motion allowed
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  // drive status
  input wire logic motor_power_on,
  input wire logic torque_mode,
  input wire logic motor_stopped,
  input wire logic ref_fwd,
  input wire logic ref_rev,
  input wire logic soft_limit_hit,
  input wire logic [9:0] motor_max_torque_pct,
  // drive commands and outputs
  output otg_drive_type drive_out,
  output logic [`OTG_NUM_GPO-1:0] gpo_out
);

  // synchroniser stages
  logic [2:0] fwd_sync_q;
  logic [2:0] rev_sync_q;
  logic fwd_ok_q;
  logic rev_ok_q;
  // registers
  logic [31:0] cfg_q;
  logic [9:0] torq_q;
  logic [1:0] outsel_q;
  logic fwd_en_q;
  logic rev_en_q;
  otg_stop_type stop_q;
  logic restart_q;
  logic clear_q;
  // supervision
  otg_state_type state_q;
  logic warn_q;
  logic armed_q;
  logic pwr_q;
  logic fwd_ot;
  logic rev_ot;
  logic any_ot;
  logic ot_event;
  logic [9:0] torq_sat;
  logic [11:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic w_have_q;
  logic wr_fire;
  logic [31:0] rd_d;

  // three stages; change counted when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fwd_sync_q <= 3'h7;
      rev_sync_q <= 3'h7;
      fwd_ok_q <= 1'b1;
      rev_ok_q <= 1'b1;
    end else begin
      fwd_sync_q <= {fwd_sync_q[1:0], fwd_limit_in};
      rev_sync_q <= {rev_sync_q[1:0], rev_limit_in};
      if (fwd_sync_q[1] == fwd_sync_q[2]) fwd_ok_q <= fwd_sync_q[2];
      if (rev_sync_q[1] == rev_sync_q[2]) rev_ok_q <= rev_sync_q[2];
    end
  end

  // overtravel flags, ignored limits never trip
  assign fwd_ot = fwd_en_q && !fwd_ok_q;
  assign rev_ot = rev_en_q && !rev_ok_q;
  assign any_ot = fwd_ot || rev_ot || soft_limit_hit;

  // axi write channel capture, address and data in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; unmapped addresses are accepted and dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_q <= `OTG_CFG_RST;
      torq_q <= `OTG_TORQ_RST;
      outsel_q <= `OTG_OUTSEL_RST;
      clear_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      restart_q <= 1'b0;
      if (wr_fire) begin
        case (aw_q[11:2])
          10'(`OTG_REG_CFG >> 2): begin
            if (ws_q[0]) cfg_q[7:0] <= w_q[7:0];
            if (ws_q[1]) cfg_q[15:8] <= w_q[15:8];
          end
          10'(`OTG_REG_TORQ >> 2): begin
            // out of range values are clipped to the legal top
            if (ws_q[0] && ws_q[1]) begin
              if (w_q[15:0] > 16'(`OTG_TORQ_MAX)) torq_q <= `OTG_TORQ_MAX;
              else torq_q <= w_q[9:0];
            end
          end
          10'(`OTG_REG_CMD >> 2): begin
            if (ws_q[0]) begin
              clear_q <= w_q[`OTG_CMD_CLEAR];
              restart_q <= w_q[`OTG_CMD_RESTART];
            end
          end
          10'(`OTG_REG_OUTSEL >> 2): begin
            if (ws_q[0]) outsel_q <= w_q[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // start-up copies of limit and stop settings
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fwd_en_q <= 1'b1;
      rev_en_q <= 1'b1;
      stop_q <= OTG_STOP_COAST;
    end else if (restart_q) begin
      fwd_en_q <= cfg_q[`OTG_CFG_FWD_EN];
      rev_en_q <= cfg_q[`OTG_CFG_REV_EN];
      // code 3 is undefined; treated as plain coast
      case (cfg_q[`OTG_CFG_STOP_HI:`OTG_CFG_STOP_LO])
        2'h1: stop_q <= OTG_STOP_DECEL_CLAMP;
        2'h2: stop_q <= OTG_STOP_DECEL_COAST;
        default: stop_q <= OTG_STOP_COAST;
      endcase
    end
  end

  // stop sequencer; no target-reached input is consulted at all
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= OTG_RUN;
    end else begin
      case (state_q)
        OTG_RUN: begin
          if ((fwd_ot && ref_fwd) || (rev_ot && ref_rev)) begin
            if (torque_mode || stop_q == OTG_STOP_COAST) state_q <= OTG_COASTING;
            else state_q <= OTG_DECEL;
          end
        end
        OTG_DECEL: begin
          if (torque_mode) state_q <= OTG_COASTING;
          else if (motor_stopped) begin
            if (stop_q == OTG_STOP_DECEL_CLAMP) state_q <= OTG_CLAMPED;
            else state_q <= OTG_COASTING;
          end
        end
        default: begin
          // leave the stop once the reference turns away or the limit clears
          if (!((fwd_ot && ref_fwd) || (rev_ot && ref_rev))) state_q <= OTG_RUN;
        end
      endcase
    end
  end

  // torque is the smaller of setting and motor maximum
  assign torq_sat = (torq_q > motor_max_torque_pct) ? motor_max_torque_pct : torq_q;

  // drive command register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      drive_out <= '0;
    end else begin
      drive_out.fwd_block <= fwd_ot;
      drive_out.rev_block <= rev_ot;
      drive_out.decel <= (state_q == OTG_DECEL);
      drive_out.coast <= (state_q == OTG_COASTING);
      drive_out.clamp <= (state_q == OTG_CLAMPED);
      drive_out.torque_pct <= torq_sat;
    end
  end

  // warning detection: direction qualified trip while powered
  assign ot_event = (fwd_ot && (ref_fwd || !ref_rev))
    || (rev_ot && (ref_rev || !ref_fwd))
    || soft_limit_hit;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      warn_q <= 1'b0;
      armed_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= motor_power_on;
      // rearm only while powered and clear of overtravel
      if (!any_ot) armed_q <= motor_power_on;
      else if (!motor_power_on) armed_q <= 1'b0;
      if (cfg_q[`OTG_CFG_WARN_EN] && motor_power_on && pwr_q && armed_q && ot_event) begin
        warn_q <= 1'b1;
        armed_q <= 1'b0;
      end else if (clear_q) begin
        warn_q <= 1'b0;
      end
    end
  end

  // warning routed to one output; drive commands ignore it
  genvar gi;
  generate
    for (gi = 0; gi < `OTG_NUM_GPO; gi = gi + 1) begin : g_gpo
      always_ff @(posedge sys_clk) begin
        if (sys_rst) gpo_out[gi] <= 1'b0;
        else gpo_out[gi] <= warn_q && (outsel_q == 2'(gi + 1));
      end
    end
  endgenerate

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (s_axi_araddr[11:2])
      10'(`OTG_REG_CFG >> 2): rd_d = {16'h0000, cfg_q[15:0]};
      10'(`OTG_REG_TORQ >> 2): rd_d = {22'h000000, torq_q};
      // code in the top bits, live status in the low nine
      10'(`OTG_REG_STAT >> 2): rd_d = {`OTG_WARN_CODE, 11'h000, state_q, warn_q, rev_ot, fwd_ot,
        stop_q, rev_en_q, fwd_en_q};
      10'(`OTG_REG_OUTSEL >> 2): rd_d = {30'h00000000, outsel_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read channel, one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // otg_top
`default_nettype wire

// [src/otg_consts.svh]
`ifndef OTG_CONSTS_SVH
`define OTG_CONSTS_SVH
// register byte offsets
`define OTG_REG_CFG 12'h000
`define OTG_REG_TORQ 12'h004
`define OTG_REG_CMD 12'h008
`define OTG_REG_STAT 12'h00c
`define OTG_REG_OUTSEL 12'h010
// cfg field positions
`define OTG_CFG_FWD_EN 0
`define OTG_CFG_REV_EN 1
`define OTG_CFG_STOP_LO 4
`define OTG_CFG_STOP_HI 5
`define OTG_CFG_WARN_EN 8
// cfg reset: both limits used, stop method 0, warning off
`define OTG_CFG_RST 32'h0000_0003
// emergency stop torque, percent of rated
`define OTG_TORQ_RST 10'h320
`define OTG_TORQ_MAX 10'h320
// cmd bits
`define OTG_CMD_CLEAR 0
`define OTG_CMD_RESTART 1
// general purpose output count and reset selection
`define OTG_NUM_GPO 3
`define OTG_OUTSEL_RST 2'h0
// warning code for the status register
`define OTG_WARN_CODE 12'h9a0
`endif

// [src/otg_pkg.sv]
package otg_pkg;
  typedef enum logic [1:0] {
    OTG_STOP_COAST,
    OTG_STOP_DECEL_CLAMP,
    OTG_STOP_DECEL_COAST
  } otg_stop_type;
  typedef enum logic [1:0] {
    OTG_RUN,
    OTG_DECEL,
    OTG_COASTING,
    OTG_CLAMPED
  } otg_state_type;
  // motion commands toward the current loop
  typedef struct packed {
    logic fwd_block;
    logic rev_block;
    logic decel;
    logic coast;
    logic clamp;
    logic [9:0] torque_pct;
  } otg_drive_type;
endpackage

// [verification/otg_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "otg_consts.svh"
module otg_checker import otg_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // drive inputs
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic motor_power_on,
  input wire logic torque_mode,
  input wire logic [9:0] motor_max_torque_pct,
  // bus response
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // outputs
  input wire otg_drive_type drive_out,
  input wire logic [`OTG_NUM_GPO-1:0] gpo_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // eight samples cover the pin filter plus the output stage
  sequence s_fwd_ok; fwd_limit_in [*8]; endsequence
  sequence s_rev_ok; rev_limit_in [*8]; endsequence
  sequence s_torq; torque_mode [*4]; endsequence
  property p_fwd_free; s_fwd_ok |-> !drive_out.fwd_block; endproperty
  a_fwd_free: assert property (p_fwd_free) else $error("fwd blocked");
  property p_rev_free; s_rev_ok |-> !drive_out.rev_block; endproperty
  a_rev_free: assert property (p_rev_free) else $error("rev blocked");
  property p_torq_sat;
    drive_out.torque_pct <= $past(motor_max_torque_pct) && drive_out.torque_pct <= 10'h320;
  endproperty
  a_torq_sat: assert property (p_torq_sat) else $error("torque high");
  property p_torq_coast; s_torq |-> !drive_out.decel; endproperty
  a_torq_coast: assert property (p_torq_coast) else $error("decel in torque");
  property p_clamp; drive_out.clamp |-> !(drive_out.coast || drive_out.decel); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp mixed");
  property p_decel_end; $fell(drive_out.decel) |-> drive_out.clamp || drive_out.coast; endproperty
  a_decel_end: assert property (p_decel_end) else $error("decel exit");
  // warning needs two powered samples, gpo lags one more
  property p_warn_pwr;
    $rose(|gpo_out) |-> $past(motor_power_on, 2) && $past(motor_power_on, 3);
  endproperty
  a_warn_pwr: assert property (p_warn_pwr) else $error("warn unpowered");
  property p_resp;
    s_axi_bvalid && s_axi_bready |-> s_axi_bresp == 2'h0 ##1 !s_axi_bvalid;
  endproperty
  a_resp: assert property (p_resp) else $error("bad response");
endmodule // otg_checker
bind otg_top otg_checker u_chk (.sys_clk, .sys_rst, .fwd_limit_in, .rev_limit_in,
  .motor_power_on, .torque_mode, .motor_max_torque_pct, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .drive_out, .gpo_out);
`default_nettype wire

// [verification/otg_switch_model.sv]
`timescale 1ns/1ns
`default_nettype none
module otg_switch_model (
  // bench clock
  input wire logic clk,
  // requested trips
  input wire logic fwd_trip,
  input wire logic rev_trip,
  // normally closed contacts
  output logic fwd_limit_in = 1,
  output logic rev_limit_in = 1
);
  // contacts open off the clock grid, pins are asynchronous
  always @(posedge clk) begin
    fwd_limit_in <= #13 !fwd_trip;
    rev_limit_in <= #13 !rev_trip;
  end
endmodule // otg_switch_model
`default_nettype wire

// [verification/overtravel_guard_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "otg_consts.svh"
module overtravel_guard_bench import otg_pkg::*;;
  // clock, reset and bus
  logic sys_clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  // drive side
  logic fwd_limit_in, rev_limit_in, fwd_trip = 0, rev_trip = 0, motor_power_on = 0;
  logic torque_mode = 0, motor_stopped = 0, ref_fwd = 0, ref_rev = 0, soft_limit_hit = 0;
  logic [9:0] motor_max_torque_pct = 10'h320, v, m;
  otg_drive_type drive_out;
  logic [`OTG_NUM_GPO-1:0] gpo_out;
  int failures = 0, cmp_count = 0, k;
  always #25 sys_clk = ~sys_clk;
  otg_top uut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fwd_limit_in, .rev_limit_in, .motor_power_on, .torque_mode,
    .motor_stopped, .ref_fwd, .ref_rev, .soft_limit_hit, .motor_max_torque_pct, .drive_out,
    .gpo_out);
  otg_switch_model sw (.clk(sys_clk), .fwd_trip, .rev_trip, .fwd_limit_in, .rev_limit_in);
  // compares for register reads and port values
  task chk_reg(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_out(input string n, input logic [9:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // handshakes sampled at the rising edge; one idle edge keeps calls apart
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 0;
    @(posedge sys_clk);
  endtask
  task rdr(input logic [11:0] a);
    logic done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
    end
    s_axi_rready <= 0;
    @(posedge sys_clk);
  endtask
  // applied torque: register clip, then motor ceiling
  function logic [9:0] sat(input logic [9:0] t, mx);
    sat = t > `OTG_TORQ_MAX ? `OTG_TORQ_MAX : t;
    if (mx < sat) sat = mx;
  endfunction
  task tr(input logic f, r);
    fwd_trip <= f;
    rev_trip <= r;
    step(3);
    fwd_trip <= 0;
    rev_trip <= 0;
    step(8);
  endtask
  // warning check, then a clear that must drop it
  task wexp(input string n, input logic e);
    chk_out(n, {9'h0, e}, 10'(gpo_out));
    wr(`OTG_REG_CMD, 32'h1);
    step(3);
    chk_out("clear", 10'h0, 10'(gpo_out));
  endtask
  initial begin
    void'($urandom(32'hdd4fe9bb));
    step(6);
    sys_rst <= 0;
    motor_power_on <= 1;
    rdr(`OTG_REG_CFG);
    chk_reg("cfg", `OTG_CFG_RST, rd);
    rdr(`OTG_REG_TORQ);
    chk_reg("torq", 32'(`OTG_TORQ_RST), rd);
    rdr(`OTG_REG_STAT);
    chk_reg("code", 32'(`OTG_WARN_CODE), {20'h0, rd[31:20]});
    rdr(12'h100);
    chk_reg("unmapped", 32'h0, rd);
    chk_reg("rresp", 32'h0, {30'h0, rr});
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 10'h3ff : 10'($urandom_range(1023));
      m = 10'($urandom_range(900));
      motor_max_torque_pct <= m;
      wr(`OTG_REG_TORQ, {22'h0, v});
      rdr(`OTG_REG_TORQ);
      chk_reg("torq_rd", {22'h0, sat(v, 10'h3ff)}, rd);
      chk_out("torq_out", sat(v, m), drive_out.torque_pct);
    end
    $display("test regs done");
    wr(`OTG_REG_OUTSEL, 32'h1);
    fwd_trip <= 1;
    step(8);
    chk_out("fwd_block", 10'h1, 10'(drive_out.fwd_block));
    chk_out("rev_free", 10'h0, 10'(drive_out.rev_block));
    chk_out("warn_off", 10'h0, 10'(gpo_out));
    fwd_trip <= 0;
    rev_trip <= 1;
    step(8);
    chk_out("rev_block", 10'h1, 10'(drive_out.rev_block));
    fwd_trip <= 1;
    wr(`OTG_REG_CFG, 32'h0);
    step(8);
    chk_out("no_restart", 10'h1, 10'(drive_out.fwd_block));
    wr(`OTG_REG_CMD, 32'h2);
    step(8);
    chk_out("fwd_ign", 10'h0, 10'(drive_out.fwd_block));
    chk_out("rev_ign", 10'h0, 10'(drive_out.rev_block));
    fwd_trip <= 0;
    rev_trip <= 0;
    $display("test limits done");
    // every stop method, then decel-clamp under torque control
    for (int i = 0; i < 4; i++) begin
      k = i == 3 ? 1 : i;
      wr(`OTG_REG_CFG, 32'h3 | 32'(k << 4));
      wr(`OTG_REG_CMD, 32'h2);
      torque_mode <= i == 3;
      ref_fwd <= 1;
      step(4);
      fwd_trip <= 1;
      step(10);
      chk_out("decel", 10'(k != 0 && i != 3), 10'(drive_out.decel));
      motor_stopped <= 1;
      step(6);
      chk_out("clamp", 10'(k == 1 && i != 3), 10'(drive_out.clamp));
      chk_out("coast", 10'(k != 1 || i == 3), 10'(drive_out.coast));
      fwd_trip <= 0;
      ref_fwd <= 0;
      motor_stopped <= 0;
      torque_mode <= 0;
      step(10);
    end
    $display("test stop done");
    wr(`OTG_REG_CFG, 32'h103);
    tr(1, 0);
    wexp("w_noref", 1);
    ref_fwd <= 1;
    tr(0, 1);
    wexp("w_opp", 0);
    tr(1, 0);
    wexp("w_same", 1);
    ref_fwd <= 0;
    soft_limit_hit <= 1;
    step(1);
    soft_limit_hit <= 0;
    step(4);
    wexp("w_soft", 1);
    motor_power_on <= 0;
    tr(0, 1);
    wexp("w_off", 0);
    rev_trip <= 1;
    step(6);
    motor_power_on <= 1;
    step(8);
    chk_out("w_pwr", 10'h0, 10'(gpo_out));
    rev_trip <= 0;
    step(8);
    rev_trip <= 1;
    step(8);
    wexp("w_held", 1);
    step(8);
    chk_out("w_stay", 10'h0, 10'(gpo_out));
    rev_trip <= 0;
    step(8);
    tr(0, 1);
    motor_power_on <= 0;
    wexp("w_rearm", 1);
    $display("test warning done");
    summarize;
  end
  // hang guard, far beyond the planned run
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize;
  end
endmodule // overtravel_guard_bench
`default_nettype wire
